// ===== logic/gpiopc_pkg.sv
package gpiopc_pkg;
  localparam logic [15:0] PORT_B_DATA_OFS = 16'hFFD7;
  localparam logic [15:0] PORT_B_DIR_OFS = 16'hFFE7;
  localparam logic [17:0] PORT_B_DATA_ADDR = {PORT_B_DATA_OFS, 2'b00};
  localparam logic [17:0] PORT_B_DIR_ADDR = {PORT_B_DIR_OFS, 2'b00};
  localparam logic [17:0] PORT_A_PU_ADDR = 18'h00000;
  localparam logic [17:0] PORT_A_DIR_ADDR = 18'h00004;
  localparam logic [17:0] SER_CTRL_ADDR = 18'h00008;
  localparam logic [17:0] POWER_MODE_ADDR = 18'h0000C;
  localparam logic [7:0] PORT_B_RESET = 8'hF8;
  localparam logic [7:0] PORT_A_RESET = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [2:0] PORT_B_RW_MASK = 3'h7;
  localparam int B_IN_BIT = 3;
  localparam int B_TX_BIT = 2;
  localparam int B_RX_BIT = 1;
  localparam int B_CK_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PM_ACTIVE = 3'h0,
    PM_SUBACTIVE = 3'h1,
    PM_SLEEP = 3'h2,
    PM_SUBSLEEP = 3'h3,
    PM_WATCH = 3'h4,
    PM_STANDBY = 3'h5
  } gpiopc_pmode_t;

  typedef struct packed {
    logic tx_on;
    logic rx_on;
    logic clk_source_hi;
    logic clk_source_lo;
    logic sync_mode_select;
    logic serial2_tx_pin_select;
    logic ext_int0_select;
  } gpiopc_serctl_t;

  typedef struct packed {
    logic [3:0] pin_in;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
  } gpiopc_portb_t;
endpackage

// ===== logic/gpiopc_port_b_mux.sv
`timescale 1ns/100ps
`default_nettype none
module gpiopc_port_b_mux (
  input wire logic [2:0] dir, // port b direction bits
  input wire logic [2:0] latch, // port b data latch bits
  input wire gpiopc_pkg::gpiopc_serctl_t ctl, // serial pin control
  input wire logic tx_data, // serial transmit data
  input wire logic clk_data, // serial clock out data
  output logic [2:0] pin_out, // pin drive levels
  output logic [2:0] pin_oe, // pin drive enables
  output logic [2:0] gp_sel // pin owned by general io
);
  always_comb begin
    gp_sel = 3'h7;
    pin_out = latch;
    pin_oe = dir;
    if (ctl.serial2_tx_pin_select && ctl.tx_on) begin
      gp_sel[gpiopc_pkg::B_TX_BIT] = 1'b0;
      pin_out[gpiopc_pkg::B_TX_BIT] = tx_data;
      pin_oe[gpiopc_pkg::B_TX_BIT] = 1'b1;
    end
    if (ctl.rx_on) begin
      gp_sel[gpiopc_pkg::B_RX_BIT] = 1'b0;
      pin_out[gpiopc_pkg::B_RX_BIT] = 1'b0;
      pin_oe[gpiopc_pkg::B_RX_BIT] = 1'b0;
    end
    if (ctl.clk_source_hi) begin
      gp_sel[gpiopc_pkg::B_CK_BIT] = 1'b0;
      pin_out[gpiopc_pkg::B_CK_BIT] = 1'b0;
      pin_oe[gpiopc_pkg::B_CK_BIT] = 1'b0;
    end else if (ctl.clk_source_lo || ctl.sync_mode_select) begin
      gp_sel[gpiopc_pkg::B_CK_BIT] = 1'b0;
      pin_out[gpiopc_pkg::B_CK_BIT] = clk_data;
      pin_oe[gpiopc_pkg::B_CK_BIT] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== logic/gpiopc_top.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - port a hi-z in reset/standby, holds in sleeps
// - standby pull-up pins show high
// - pull-up on when direction 0, enable 1
// - pull-ups off after reset
// - port b: three io pins, one input
// - data latch resets F8, upper ones
// - read gives latch if output, else pin
// - direction 1 output, 0 input
// - direction register resets F8
// - direction register write-only, reads ones
// - general settings only when pin unassigned
// - bit 2 transmit when select and enabled
// - bit 1 receive when receive enabled
// - bit 0 serial clock per clock source, output also in sync mode
module gpiopc_top (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [17:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [17:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic [7:0] port_a_in, // port a pin levels
  input wire logic [7:0] port_a_out_req, // port a drive from port logic
  output logic [7:0] port_a_oe, // port a drive enables
  output logic [7:0] port_a_out, // port a drive levels
  output logic [7:0] port_a_pullup, // port a pull-up on
  input wire logic [3:0] port_b_in, // port b pin levels
  output logic [2:0] port_b_out, // port b drive levels
  output logic [2:0] port_b_oe, // port b drive enables
  input wire logic serial2_tx_pin, // serial transmit data
  input wire logic serial2_clk_out, // serial clock out data
  output logic serial2_rx_pin, // serial receive data
  output logic serial2_clk_in, // serial clock in
  output logic ext_int0_in // interrupt 0 input level
);
  logic [7:0] a_pu_q, a_dir_q;
  logic [7:0] a_hold_out_q, a_hold_oe_q;
  logic [2:0] b_lat_q, b_dir_q;
  gpiopc_pkg::gpiopc_serctl_t ctl_q;
  gpiopc_pkg::gpiopc_pmode_t pm_q;
  logic [3:0] b_s1_q, b_s2_q;
  logic [7:0] a_s1_q, a_s2_q;
  logic [2:0] mux_out, mux_oe;
  logic [17:0] aw_q;
  logic aw_have_q, w_have_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic [31:0] rd_d;
  logic rd_ok_d;
  logic do_wr;

  function automatic logic known_addr(input logic [17:0] a);
    known_addr = (a == gpiopc_pkg::PORT_B_DATA_ADDR) || (a == gpiopc_pkg::PORT_B_DIR_ADDR) ||
                 (a == gpiopc_pkg::PORT_A_PU_ADDR) || (a == gpiopc_pkg::PORT_A_DIR_ADDR) ||
                 (a == gpiopc_pkg::SER_CTRL_ADDR) || (a == gpiopc_pkg::POWER_MODE_ADDR);
  endfunction

  always_ff @(posedge aclk) begin
    b_s1_q <= port_b_in;
    b_s2_q <= b_s1_q;
    a_s1_q <= port_a_in;
    a_s2_q <= a_s1_q;
  end

  // write channel capture
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign do_wr = aw_have_q && w_have_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 18'h00000;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gpiopc_pkg::RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= known_addr(aw_q) ? gpiopc_pkg::RESP_OKAY : gpiopc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes, only low byte lane meaningful
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b_lat_q <= gpiopc_pkg::PORT_B_RESET[2:0];
      b_dir_q <= gpiopc_pkg::PORT_B_RESET[2:0];
      a_pu_q <= gpiopc_pkg::PORT_A_RESET;
      a_dir_q <= gpiopc_pkg::PORT_A_RESET;
      ctl_q <= '0;
      pm_q <= gpiopc_pkg::PM_ACTIVE;
    end else if (do_wr && ws_q[0]) begin
      case (aw_q)
        gpiopc_pkg::PORT_B_DATA_ADDR: b_lat_q <= wd_q[2:0] & gpiopc_pkg::PORT_B_RW_MASK;
        gpiopc_pkg::PORT_B_DIR_ADDR: b_dir_q <= wd_q[2:0];
        gpiopc_pkg::PORT_A_PU_ADDR: a_pu_q <= wd_q[7:0];
        gpiopc_pkg::PORT_A_DIR_ADDR: a_dir_q <= wd_q[7:0];
        gpiopc_pkg::SER_CTRL_ADDR: ctl_q <= gpiopc_pkg::gpiopc_serctl_t'(wd_q[6:0]);
        gpiopc_pkg::POWER_MODE_ADDR: pm_q <= gpiopc_pkg::gpiopc_pmode_t'(wd_q[2:0]);
        default: ;
      endcase
    end
  end

  // read path
  always_comb begin
    rd_d = 32'h00000000;
    rd_ok_d = 1'b1;
    case (s_axi_araddr)
      gpiopc_pkg::PORT_B_DATA_ADDR: begin
        rd_d[7:0] = gpiopc_pkg::PORT_B_RESET;
        rd_d[gpiopc_pkg::B_IN_BIT] = b_s2_q[gpiopc_pkg::B_IN_BIT];
        for (int i = 0; i < 3; i++) begin
          rd_d[i] = b_dir_q[i] ? b_lat_q[i] : b_s2_q[i];
        end
      end
      gpiopc_pkg::PORT_B_DIR_ADDR: rd_d[7:0] = gpiopc_pkg::ALL_ONES;
      gpiopc_pkg::PORT_A_PU_ADDR: rd_d[7:0] = a_pu_q;
      gpiopc_pkg::PORT_A_DIR_ADDR: rd_d[7:0] = a_s2_q;
      gpiopc_pkg::SER_CTRL_ADDR: rd_d[6:0] = ctl_q;
      gpiopc_pkg::POWER_MODE_ADDR: rd_d[2:0] = pm_q;
      default: rd_ok_d = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= gpiopc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= rd_ok_d ? gpiopc_pkg::RESP_OKAY : gpiopc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  gpiopc_port_b_mux u_mux (
    .dir(b_dir_q),
    .latch(b_lat_q),
    .ctl(ctl_q),
    .tx_data(serial2_tx_pin),
    .clk_data(serial2_clk_out),
    .pin_out(mux_out),
    .pin_oe(mux_oe),
    .gp_sel()
  );

  // port b pin state per power mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_b_out <= 3'h0;
      port_b_oe <= 3'h0;
    end else begin
      case (pm_q)
        gpiopc_pkg::PM_ACTIVE, gpiopc_pkg::PM_SUBACTIVE: begin
          port_b_out <= mux_out;
          port_b_oe <= mux_oe;
        end
        gpiopc_pkg::PM_STANDBY: begin
          port_b_out <= 3'h0;
          port_b_oe <= 3'h0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial2_rx_pin <= 1'b1;
      serial2_clk_in <= 1'b0;
      ext_int0_in <= 1'b0;
    end else begin
      serial2_rx_pin <= ctl_q.rx_on ? b_s2_q[gpiopc_pkg::B_RX_BIT] : 1'b1;
      serial2_clk_in <= ctl_q.clk_source_hi & b_s2_q[gpiopc_pkg::B_CK_BIT];
      ext_int0_in <= ctl_q.ext_int0_select & b_s2_q[gpiopc_pkg::B_IN_BIT];
    end
  end

  // port a: pull-ups and per-mode pin state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_pullup <= 8'h00;
      port_a_oe <= 8'h00;
      port_a_out <= 8'h00;
      a_hold_out_q <= 8'h00;
      a_hold_oe_q <= 8'h00;
    end else begin
      port_a_pullup <= a_pu_q & ~a_dir_q;
      case (pm_q)
        gpiopc_pkg::PM_ACTIVE, gpiopc_pkg::PM_SUBACTIVE: begin
          port_a_oe <= a_dir_q;
          port_a_out <= port_a_out_req;
          a_hold_out_q <= port_a_out_req;
          a_hold_oe_q <= a_dir_q;
        end
        gpiopc_pkg::PM_STANDBY: begin
          port_a_oe <= 8'h00;
          port_a_out <= 8'h00;
        end
        default: begin
          port_a_oe <= a_hold_oe_q;
          port_a_out <= a_hold_out_q;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verif/gpiopc_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module gpiopc_top_assertions (
  input wire logic aclk, // clk
  input wire logic aresetn, // rst
  input wire logic s_axi_awvalid, // aw
  input wire logic s_axi_awready, // aw
  input wire logic s_axi_wvalid, // w
  input wire logic s_axi_wready, // w
  input wire logic [1:0] s_axi_bresp, // b
  input wire logic s_axi_bvalid, // b
  input wire logic s_axi_bready, // b
  input wire logic [17:0] s_axi_araddr, // ar
  input wire logic s_axi_arvalid, // ar
  input wire logic s_axi_arready, // ar
  input wire logic [31:0] s_axi_rdata, // r
  input wire logic [1:0] s_axi_rresp, // r
  input wire logic s_axi_rvalid, // r
  input wire logic s_axi_rready, // r
  input wire logic [7:0] port_a_oe, // pins
  input wire logic [7:0] port_a_pullup, // pins
  input wire logic [2:0] port_b_oe, // pins
  input wire logic serial2_rx_pin // rx
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [17:0] ar_q;
  logic map_w;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  assign map_w = ar_q inside {gpiopc_pkg::PORT_B_DATA_ADDR, gpiopc_pkg::PORT_B_DIR_ADDR, gpiopc_pkg::PORT_A_PU_ADDR,
    gpiopc_pkg::PORT_A_DIR_ADDR, gpiopc_pkg::SER_CTRL_ADDR, gpiopc_pkg::POWER_MODE_ADDR};
  property p_rst;
    disable iff (1'b0) !aresetn |=> port_a_oe == 8'h00 && port_a_pullup == 8'h00 && port_b_oe == 3'h0 && serial2_rx_pin;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs wrong");
  property p_pu_oe;
    (port_a_pullup & port_a_oe) == 8'h00;
  endproperty
  a_pu_oe: assert property (p_pu_oe) else $error("pull-up on driven pin");
  property p_dir_ones;
    s_axi_rvalid && ar_q == gpiopc_pkg::PORT_B_DIR_ADDR |-> s_axi_rdata[7:0] == 8'hFF;
  endproperty
  a_dir_ones: assert property (p_dir_ones) else $error("direction read not ones");
  property p_data_up;
    s_axi_rvalid && ar_q == gpiopc_pkg::PORT_B_DATA_ADDR |-> s_axi_rdata[7:4] == 4'hF;
  endproperty
  a_data_up: assert property (p_data_up) else $error("latch upper bits not ones");
  property p_unmap;
    s_axi_rvalid && !map_w |-> s_axi_rresp == gpiopc_pkg::RESP_SLVERR;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_busy;
    s_axi_bvalid || s_axi_rvalid |-> !(s_axi_bvalid && s_axi_awready) && !(s_axi_rvalid && s_axi_arready);
  endproperty
  a_busy: assert property (p_busy) else $error("request taken while busy");
endmodule
bind gpiopc_top gpiopc_top_assertions i_chk (.*);
`default_nettype wire

// ===== verif/gpiopc_board.sv
`timescale 1ns/100ps
`default_nettype none
module gpiopc_board (
  input wire logic aclk, // clk
  input wire logic [2:0] port_b_out, // b drive
  input wire logic [2:0] port_b_oe, // b enable
  input wire logic [3:0] b_ext, // board levels
  input wire logic [7:0] port_a_out, // a drive
  input wire logic [7:0] port_a_oe, // a enable
  input wire logic [7:0] port_a_pullup, // a pull-up
  output logic [3:0] port_b_in, // b wire
  output logic [7:0] port_a_in // a wire
);
  logic t_q = 1'b0;
  // floating pins wander
  always_ff @(posedge aclk) begin
    t_q <= ~t_q;
  end
  assign port_b_in = {b_ext[3], (port_b_oe & port_b_out) | (~port_b_oe & b_ext[2:0])};
  assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & (port_a_pullup | {8{t_q}}));
endmodule
`default_nettype wire

// ===== verif/gpio_port_pin_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module gpio_port_pin_control_bench;
  typedef struct packed {
    logic [17:0] wa;
    logic [7:0] wd;
    logic [17:0] ra;
    logic [7:0] re;
    logic [2:0] oe;
    logic [7:0] pu;
  } gpiopc_row_t;
  localparam logic [17:0] BD = gpiopc_pkg::PORT_B_DATA_ADDR;
  localparam logic [17:0] BR = gpiopc_pkg::PORT_B_DIR_ADDR;
  localparam logic [17:0] PU = gpiopc_pkg::PORT_A_PU_ADDR;
  localparam logic [17:0] AR = gpiopc_pkg::PORT_A_DIR_ADDR;
  localparam logic [17:0] SR = gpiopc_pkg::SER_CTRL_ADDR;
  localparam logic [17:0] PM = gpiopc_pkg::POWER_MODE_ADDR;
  localparam gpiopc_row_t ROWS [8] = '{'{BR, 8'h07, BD, 8'hF8, 3'h7, 8'h00}, '{BD, 8'hFD, BD, 8'hFD, 3'h7, 8'h00},
    '{BR, 8'h02, BD, 8'hF8, 3'h2, 8'h00}, '{BR, 8'hFF, BR, 8'hFF, 3'h7, 8'h00}, '{BR, 8'h00, BD, 8'hFA, 3'h0, 8'h00},
    '{AR, 8'h0F, PU, 8'h00, 3'h0, 8'h00}, '{PU, 8'hFF, PU, 8'hFF, 3'h0, 8'hF0}, '{AR, 8'hF0, PU, 8'hFF, 3'h0, 8'h0F}};
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, serial2_tx_pin = 1'b1, serial2_clk_out = 1'b1;
  logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, b_ext = 4'hA, port_b_in;
  logic [7:0] port_a_in, port_a_out_req = 8'h00, port_a_oe, port_a_out, port_a_pullup;
  logic [2:0] port_b_out, port_b_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial2_rx_pin, serial2_clk_in, ext_int0_in;
  int err_count = 0;
  int comparisons = 0;
  logic [1:0] b_seen = 2'h0;
  gpiopc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_in, .port_a_out_req, .port_a_oe,
    .port_a_out, .port_a_pullup, .port_b_in, .port_b_out, .port_b_oe, .serial2_tx_pin, .serial2_clk_out,
    .serial2_rx_pin, .serial2_clk_in, .ext_int0_in);
  gpiopc_board i_board (.aclk, .port_b_out, .port_b_oe, .b_ext, .port_a_out, .port_a_oe, .port_a_pullup, .port_b_in,
    .port_a_in);
  always #2 aclk = ~aclk;
  task automatic stop_test;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wt(input logic ok);
    if (ok !== 1'b1) begin
      err_count++;
      stop_test;
    end
  endtask
  task automatic settle;
    repeat (4) @(posedge aclk);
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] dv);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    b_seen = s_axi_bresp;
    s_axi_bready <= 1'b0;
    wt(s_axi_bvalid);
  endtask
  task automatic rd(input logic [17:0] a, output logic [31:0] dv, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    dv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    wt(s_axi_rvalid);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(BD, d, r);
    chk(d, 32'hFA);
    rd(BR, d, r);
    chk(d, 32'hFF);
    chk(port_b_oe, 3'h0);
    chk(port_a_pullup, 8'h00);
    $display("reset test done");
    foreach (ROWS[i]) begin
      wr(ROWS[i].wa, ROWS[i].wd);
      chk(b_seen, gpiopc_pkg::RESP_OKAY);
      // pin levels pass two sync stages before a read sees them
      settle;
      rd(ROWS[i].ra, d, r);
      chk(d, ROWS[i].re);
      chk(r, gpiopc_pkg::RESP_OKAY);
      chk(port_b_oe, ROWS[i].oe);
      chk(port_a_pullup, ROWS[i].pu);
    end
    $display("table test done");
    wr(SR, 32'h43);
    settle;
    chk({port_b_oe, port_b_out[2]}, 4'h9);
    chk(ext_int0_in, 1'b1);
    wr(BR, 32'h02);
    wr(SR, 32'h20);
    b_ext <= 4'h9;
    settle;
    chk(port_b_oe, 3'h0);
    chk({serial2_rx_pin, ext_int0_in}, 2'h0);
    wr(SR, 32'h10);
    settle;
    chk({port_b_oe, serial2_clk_in}, 4'h5);
    wr(SR, 32'h08);
    settle;
    chk({port_b_oe, port_b_out[0]}, 4'h7);
    wr(SR, 32'h04);
    settle;
    chk(port_b_oe, 3'h3);
    $display("serial test done");
    wr(PM, 32'h5);
    settle;
    chk({port_a_oe, port_a_pullup}, 16'h000F);
    rd(AR, d, r);
    chk(d[3:0], 4'hF);
    wr(PM, 32'h0);
    wr(AR, 32'hFF);
    port_a_out_req <= 8'h3C;
    wr(PM, 32'h2);
    port_a_out_req <= 8'hC3;
    settle;
    chk(port_a_out, 8'h3C);
    wr(PM, 32'h0);
    settle;
    chk({port_a_oe, port_a_out}, 16'hFFC3);
    rd(18'h00100, d, r);
    chk(r, gpiopc_pkg::RESP_SLVERR);
    wr(18'h00100, 32'hFF);
    chk(b_seen, gpiopc_pkg::RESP_SLVERR);
    rd(PU, d, r);
    chk(d, 32'hFF);
    $display("power test done");
    b_ext <= 4'h0;
    settle;
    rd(BD, d, r);
    chk(d, 32'hF1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(BD, d, r);
    chk(d, 32'hF0);
    chk({port_b_oe, port_a_pullup}, 11'h000);
    $display("reset again test done");
    stop_test;
  end
endmodule
`default_nettype wire
